//--- hw/mrsp_regs.svh
// register offsets, reset values and selector codes for the mute ramp / status pin block
// assumes byte-wide registers behind an 8-bit register pointer
`ifndef MRSP_REGS_SVH
`define MRSP_REGS_SVH

// register offsets
`define MRSP_OFS_EMERG 8'h40
`define MRSP_OFS_AMUTE 8'h41
`define MRSP_OFS_SEL1 8'h52
`define MRSP_OFS_SEL0 8'h53

// reset values
`define MRSP_RST_EMERG 8'h02
`define MRSP_RST_AMUTE 8'h04
`define MRSP_RST_SEL 8'h00

// field positions
`define MRSP_EMERG_RATE 7:6
`define MRSP_EMERG_STEP 5:4
`define MRSP_AMUTE_JOINT 2
`define MRSP_AMUTE_EN_A 1
`define MRSP_AMUTE_EN_B 0
`define MRSP_SEL_FIELD 4:0

// emergency rate codes and volume levels
`define MRSP_RATE_INSTANT 2'h3
`define MRSP_VOL_MUTE 8'hff

// bus address of the device on the control port (value arbitrary)
`define MRSP_DEV_ADDR 7'h4c

// pin selector codes
`define MRSP_SEL_LOW 5'h00
`define MRSP_SEL_DSP 5'h01
`define MRSP_SEL_REG 5'h02
`define MRSP_SEL_AM_BOTH 5'h03
`define MRSP_SEL_AM_B 5'h04
`define MRSP_SEL_AM_A 5'h05
`define MRSP_SEL_CLK_BAD 5'h06
`define MRSP_SEL_SDATA 5'h07
`define MRSP_SEL_AMUTE_B_N 5'h08
`define MRSP_SEL_AMUTE_A_N 5'h09
`define MRSP_SEL_PLL_LOCK 5'h0a
`define MRSP_SEL_CP_CLK 5'h0b
`define MRSP_SEL_UV_HIGH 5'h0e
`define MRSP_SEL_UV_LOW 5'h0f
`define MRSP_SEL_PLL_DIV4 5'h10

`endif

//--- hw/mrsp_pkg.sv
// types shared by the mute ramp / status pin block
// assumes mrsp_regs.svh carries all numeric constants
package mrsp_pkg;
   typedef enum logic [2:0] {
      I2C_IDLE,
      I2C_ADDR,
      I2C_ADDR_ACK,
      I2C_WR_BYTE,
      I2C_WR_ACK,
      I2C_RD_BYTE,
      I2C_RD_ACK
   } mrsp_i2c_state_e;

   typedef logic [7:0] mrsp_byte_t;
endpackage : mrsp_pkg

//--- hw/mrsp_src_if.sv
// status signals offered to the general pin selectors
// assumes every signal is already in the clk domain
`timescale 1ns/100ps
interface mrsp_src_if;
   logic am_both;
   logic am_a;
   logic am_b;
   logic clk_bad;
   logic sdata;
   logic amute_a_n;
   logic amute_b_n;
   logic pll_lock;
   logic cp_clk;
   logic uv_high;
   logic uv_low;
   logic pll_div4;

   modport drv (output am_both, am_a, am_b, clk_bad, sdata, amute_a_n, amute_b_n,
                output pll_lock, cp_clk, uv_high, uv_low, pll_div4);
   modport sel (input am_both, am_a, am_b, clk_bad, sdata, amute_a_n, amute_b_n,
                input pll_lock, cp_clk, uv_high, uv_low, pll_div4);
endinterface : mrsp_src_if

//--- hw/mrsp_pin_mux.sv
// one general pin output selector with registered pin and enable
// assumes sources in the clk domain; direction bit comes from outside
`timescale 1ns/100ps
`include "mrsp_regs.svh"
module mrsp_pin_mux (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // selection
   input wire logic [4:0] sel,
   input wire logic dsp_level,
   input wire logic reg_level,
   input wire logic is_output,
   mrsp_src_if.sel src,
   // pin
   output logic pin_out,
   output logic pin_oe_n
);
   logic next_pin_out;

   always_comb begin
      unique case (sel)
         `MRSP_SEL_LOW: next_pin_out = 1'b0; // [R10]
         `MRSP_SEL_DSP: next_pin_out = dsp_level; // [R10]
         `MRSP_SEL_REG: next_pin_out = reg_level; // [R10] [R17] [R18]
         `MRSP_SEL_AM_BOTH: next_pin_out = src.am_both; // [R11]
         `MRSP_SEL_AM_B: next_pin_out = src.am_b; // [R11]
         `MRSP_SEL_AM_A: next_pin_out = src.am_a; // [R11]
         `MRSP_SEL_CLK_BAD: next_pin_out = src.clk_bad; // [R12]
         `MRSP_SEL_SDATA: next_pin_out = src.sdata; // [R12]
         `MRSP_SEL_AMUTE_B_N: next_pin_out = src.amute_b_n; // [R13]
         `MRSP_SEL_AMUTE_A_N: next_pin_out = src.amute_a_n; // [R13]
         `MRSP_SEL_PLL_LOCK: next_pin_out = src.pll_lock; // [R13]
         `MRSP_SEL_CP_CLK: next_pin_out = src.cp_clk; // [R14]
         `MRSP_SEL_UV_HIGH: next_pin_out = src.uv_high; // [R15]
         `MRSP_SEL_UV_LOW: next_pin_out = src.uv_low; // [R15]
         `MRSP_SEL_PLL_DIV4: next_pin_out = src.pll_div4; // [R14]
         // reserved codes park the pin low
         default: next_pin_out = 1'b0; // [R14]
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_out <= 1'b0;
         pin_oe_n <= 1'b1;
      end else begin
         pin_out <= next_pin_out;
         // selection only reaches the pad once software makes it an output
         pin_oe_n <= ~is_output; // [R9] [R16]
      end
   end
endmodule : mrsp_pin_mux

//--- hw/mrsp_top.sv
// emergency ramp, auto-mute policy and general pin selectors behind the control port
// assumes fs_tick, volumes and zero flags come from logic on clk; pins are synchronised here
`timescale 1ns/100ps
`include "mrsp_regs.svh"

// Summary of operation
// R1 - rate field 7:6 updates every 1, 2 or 4 samples, or mutes at once
// R2 - step field 5:4 lowers volume by 4, 2, 1 or 0.5 dB per update
// R3 - emergency ramp settings govern ramps caused by clock error or power loss
// R4 - policy bit 2 mutes channels independently, or both only when both qualify
// R5 - a channel auto-mutes once its zero samples last the configured time
// R6 - auto-mute register bit 1 enables auto-mute for channel A
// R7 - auto-mute register bit 0 enables auto-mute for channel B
// R8 - with joint policy, one channel disabled keeps the other from muting too
// R9 - pin one drives its selected signal once software sets it to output
// R10 - codes 0, 1, 2 give low, processor pin output, register bit
// R11 - codes 3, 4, 5 give both-muted, channel B, channel A auto-mute flags
// R12 - code 6 gives clock-invalid flag, code 7 the serial audio data output
// R13 - codes 8, 9 give low-active analog mutes B, A; code 10 PLL lock
// R14 - code 11 charge pump clock, code 16 PLL output over four; others reserved
// R15 - codes 14 and 15 give the high and low threshold undervoltage flags
// R16 - pin zero has its own selector with the same codes, also needing output mode
// R17 - register code drives pin zero from output control bit 3
// R18 - register code drives pin one from output control bit 2
// R19 - emergency ramp subtracts one step per update, never below mute
module mrsp_top (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control port pins
   input wire logic scl_pin,
   input wire logic sda_pin_in,
   output logic sda_pin_out,
   output logic sda_pin_oe_n,
   // audio path
   input wire logic fs_tick,
   input wire logic emergency_req,
   input wire logic [7:0] vol_a_in,
   input wire logic [7:0] vol_b_in,
   input wire logic zero_a,
   input wire logic zero_b,
   output logic [7:0] vol_a,
   output logic [7:0] vol_b,
   output logic automute_a,
   output logic automute_b,
   // pin controls held outside this block
   input wire logic dsp_pin0,
   input wire logic dsp_pin1,
   input wire logic pin0_level,
   input wire logic pin1_level,
   input wire logic pin0_is_output,
   input wire logic pin1_is_output,
   // status sources
   input wire logic clk_invalid,
   input wire logic serial_audio_out,
   input wire logic pll_lock,
   input wire logic cp_clk,
   input wire logic pll_div4,
   input wire logic uv_high_thresh,
   input wire logic uv_low_thresh,
   // general pins
   output logic general_pin_zero,
   output logic general_pin_zero_oe_n,
   output logic general_pin_one,
   output logic general_pin_one_oe_n
);
   mrsp_pkg::mrsp_byte_t emergency_ramp_settings;
   mrsp_pkg::mrsp_byte_t auto_mute_policy;
   mrsp_pkg::mrsp_byte_t pin1_output_select;
   mrsp_pkg::mrsp_byte_t pin0_output_select;
   mrsp_pkg::mrsp_byte_t rdata;
   mrsp_pkg::mrsp_byte_t reg_ptr;
   mrsp_pkg::mrsp_byte_t wdata;
   mrsp_pkg::mrsp_byte_t rx_shift;
   mrsp_pkg::mrsp_byte_t tx_shift;
   mrsp_pkg::mrsp_i2c_state_e i2c_state;
   logic wr_stb;
   logic [3:0] bit_cnt;
   logic first_byte;
   logic read_dir;
   logic host_nack;
   logic sda_drive;
   logic [6:0] sync1;
   logic [6:0] sync2;
   logic scl_q;
   logic sda_q;
   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic [7:0] vol [2];
   logic [7:0] vol_in [2];
   logic [1:0] rate_cnt;
   logic ramp_update;
   logic want_a;
   logic want_b;

   mrsp_src_if src ();

   // steps are in 0.5 dB codes; larger codes mean more attenuation
   function automatic logic [7:0] step_codes(input logic [1:0] sel);
      unique case (sel)
         2'h0: step_codes = 8'h08;
         2'h1: step_codes = 8'h04;
         2'h2: step_codes = 8'h02;
         2'h3: step_codes = 8'h01;
      endcase
   endfunction : step_codes

   function automatic logic [7:0] ramp_down(input logic [7:0] v, input logic [1:0] sel);
      logic [8:0] sum;
      sum = {1'b0, v} + {1'b0, step_codes(sel)};
      if (sum > {1'b0, `MRSP_VOL_MUTE}) begin
         ramp_down = `MRSP_VOL_MUTE; // [R19]
      end else begin
         ramp_down = sum[7:0]; // [R19]
      end
   endfunction : ramp_down

   // pins and foreign clocks pass two flops; stage one feeds only stage two
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1 <= 7'h03;
         sync2 <= 7'h03;
      end else begin
         sync1 <= {uv_low_thresh, uv_high_thresh, pll_div4, cp_clk, pll_lock, sda_pin_in,
                   scl_pin};
         sync2 <= sync1;
      end
   end

   assign scl_s = sync2[0];
   assign sda_s = sync2[1];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_q;
   assign scl_fall = ~scl_s & scl_q;
   assign bus_start = scl_s & scl_q & sda_q & ~sda_s;
   assign bus_stop = scl_s & scl_q & ~sda_q & sda_s;

   // register read mux, unmapped offsets read zero
   always_comb begin
      unique case (reg_ptr)
         `MRSP_OFS_EMERG: rdata = emergency_ramp_settings;
         `MRSP_OFS_AMUTE: rdata = auto_mute_policy;
         `MRSP_OFS_SEL1: rdata = pin1_output_select;
         `MRSP_OFS_SEL0: rdata = pin0_output_select;
         default: rdata = 8'h00;
      endcase
   end

   // control port slave: first written byte sets the pointer, later bytes auto-increment
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         i2c_state <= mrsp_pkg::I2C_IDLE;
         bit_cnt <= 4'h0;
         rx_shift <= 8'h00;
         tx_shift <= 8'h00;
         reg_ptr <= 8'h00;
         wdata <= 8'h00;
         wr_stb <= 1'b0;
         first_byte <= 1'b0;
         read_dir <= 1'b0;
         host_nack <= 1'b0;
         sda_drive <= 1'b0;
      end else begin
         wr_stb <= 1'b0;
         if (wr_stb) begin
            reg_ptr <= reg_ptr + 8'h01;
         end
         if (bus_start) begin
            i2c_state <= mrsp_pkg::I2C_ADDR;
            bit_cnt <= 4'h0;
            first_byte <= 1'b1;
            sda_drive <= 1'b0;
         end else if (bus_stop) begin
            i2c_state <= mrsp_pkg::I2C_IDLE;
            sda_drive <= 1'b0;
         end else begin
            unique case (i2c_state)
               mrsp_pkg::I2C_IDLE: begin
                  sda_drive <= 1'b0;
               end
               mrsp_pkg::I2C_ADDR, mrsp_pkg::I2C_WR_BYTE: begin
                  if (scl_rise) begin
                     rx_shift <= {rx_shift[6:0], sda_s};
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (scl_fall && bit_cnt == 4'h8) begin
                     if (i2c_state == mrsp_pkg::I2C_ADDR) begin
                        if (rx_shift[7:1] == `MRSP_DEV_ADDR) begin
                           sda_drive <= 1'b1;
                           read_dir <= rx_shift[0];
                           i2c_state <= mrsp_pkg::I2C_ADDR_ACK;
                        end else begin
                           i2c_state <= mrsp_pkg::I2C_IDLE;
                        end
                     end else begin
                        sda_drive <= 1'b1;
                        i2c_state <= mrsp_pkg::I2C_WR_ACK;
                        if (first_byte) begin
                           reg_ptr <= rx_shift;
                           first_byte <= 1'b0;
                        end else begin
                           wdata <= rx_shift;
                           wr_stb <= 1'b1;
                        end
                     end
                  end
               end
               mrsp_pkg::I2C_ADDR_ACK: begin
                  if (scl_fall) begin
                     if (read_dir) begin
                        tx_shift <= {rdata[6:0], 1'b0};
                        sda_drive <= ~rdata[7];
                        reg_ptr <= reg_ptr + 8'h01;
                        bit_cnt <= 4'h1;
                        i2c_state <= mrsp_pkg::I2C_RD_BYTE;
                     end else begin
                        sda_drive <= 1'b0;
                        bit_cnt <= 4'h0;
                        i2c_state <= mrsp_pkg::I2C_WR_BYTE;
                     end
                  end
               end
               mrsp_pkg::I2C_WR_ACK: begin
                  if (scl_fall) begin
                     sda_drive <= 1'b0;
                     bit_cnt <= 4'h0;
                     i2c_state <= mrsp_pkg::I2C_WR_BYTE;
                  end
               end
               mrsp_pkg::I2C_RD_BYTE: begin
                  if (scl_fall) begin
                     if (bit_cnt == 4'h8) begin
                        sda_drive <= 1'b0;
                        i2c_state <= mrsp_pkg::I2C_RD_ACK;
                     end else begin
                        sda_drive <= ~tx_shift[7];
                        tx_shift <= {tx_shift[6:0], 1'b0};
                        bit_cnt <= bit_cnt + 4'h1;
                     end
                  end
               end
               mrsp_pkg::I2C_RD_ACK: begin
                  if (scl_rise) begin
                     host_nack <= sda_s;
                  end else if (scl_fall) begin
                     if (host_nack) begin
                        i2c_state <= mrsp_pkg::I2C_IDLE;
                     end else begin
                        tx_shift <= {rdata[6:0], 1'b0};
                        sda_drive <= ~rdata[7];
                        reg_ptr <= reg_ptr + 8'h01;
                        bit_cnt <= 4'h1;
                        i2c_state <= mrsp_pkg::I2C_RD_BYTE;
                     end
                  end
               end
            endcase
         end
      end
   end

   // open drain: line is only ever pulled low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sda_pin_out <= 1'b0;
         sda_pin_oe_n <= 1'b1;
      end else begin
         sda_pin_out <= 1'b0;
         sda_pin_oe_n <= ~sda_drive;
      end
   end

   // register writes; all eight bits are kept so reads return what was written
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         emergency_ramp_settings <= `MRSP_RST_EMERG;
         auto_mute_policy <= `MRSP_RST_AMUTE;
         pin1_output_select <= `MRSP_RST_SEL;
         pin0_output_select <= `MRSP_RST_SEL;
      end else if (wr_stb) begin
         unique case (reg_ptr)
            `MRSP_OFS_EMERG: emergency_ramp_settings <= wdata;
            `MRSP_OFS_AMUTE: auto_mute_policy <= wdata;
            `MRSP_OFS_SEL1: pin1_output_select <= wdata;
            `MRSP_OFS_SEL0: pin0_output_select <= wdata;
            default: ;
         endcase
      end
   end

   // update pacing in sample periods; counter idles at zero outside an emergency
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rate_cnt <= 2'h0;
      end else if (!emergency_req) begin
         rate_cnt <= 2'h0;
      end else if (fs_tick) begin
         rate_cnt <= ramp_update ? 2'h0 : rate_cnt + 2'h1; // [R1]
      end
   end

   always_comb begin
      unique case (emergency_ramp_settings[`MRSP_EMERG_RATE])
         2'h0: ramp_update = fs_tick; // [R1]
         2'h1: ramp_update = fs_tick && rate_cnt == 2'h1; // [R1]
         2'h2: ramp_update = fs_tick && rate_cnt == 2'h3; // [R1]
         2'h3: ramp_update = 1'b0;
      endcase
   end

   assign vol_in[0] = vol_a_in;
   assign vol_in[1] = vol_b_in;

   // normal ramps belong upstream; only the emergency path is shaped here
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         vol[0] <= `MRSP_VOL_MUTE;
         vol[1] <= `MRSP_VOL_MUTE;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (!emergency_req) begin
               vol[i] <= vol_in[i];
            end else if (emergency_ramp_settings[`MRSP_EMERG_RATE] == `MRSP_RATE_INSTANT) begin
               vol[i] <= `MRSP_VOL_MUTE; // [R1] [R3]
            end else if (ramp_update) begin
               vol[i] <= ramp_down(vol[i], emergency_ramp_settings[`MRSP_EMERG_STEP]); // [R2] [R3]
            end
         end
      end
   end

   assign vol_a = vol[0];
   assign vol_b = vol[1];

   // zero flags arrive already qualified by the zero-run timer
   assign want_a = auto_mute_policy[`MRSP_AMUTE_EN_A] & zero_a; // [R5] [R6]
   assign want_b = auto_mute_policy[`MRSP_AMUTE_EN_B] & zero_b; // [R5] [R7]

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         automute_a <= 1'b0;
         automute_b <= 1'b0;
      end else if (auto_mute_policy[`MRSP_AMUTE_JOINT]) begin
         automute_a <= want_a & want_b; // [R4] [R8]
         automute_b <= want_a & want_b; // [R4] [R8]
      end else begin
         automute_a <= want_a; // [R4]
         automute_b <= want_b; // [R4]
      end
   end

   assign src.am_both = automute_a & automute_b; // [R11]
   assign src.am_a = automute_a;
   assign src.am_b = automute_b;
   assign src.clk_bad = clk_invalid; // [R12]
   assign src.sdata = serial_audio_out;
   assign src.amute_a_n = ~automute_a; // [R13]
   assign src.amute_b_n = ~automute_b; // [R13]
   assign src.pll_lock = sync2[2];
   // foreign clocks are resampled, so only slow ones survive on the pins
   assign src.cp_clk = sync2[3];
   assign src.pll_div4 = sync2[4];
   assign src.uv_high = sync2[5]; // [R15]
   assign src.uv_low = sync2[6]; // [R15]

   mrsp_pin_mux u_pin0 (
      .clk(clk),
      .rst_n(rst_n),
      .sel(pin0_output_select[`MRSP_SEL_FIELD]),
      .dsp_level(dsp_pin0),
      .reg_level(pin0_level), // [R17]
      .is_output(pin0_is_output),
      .src(src),
      .pin_out(general_pin_zero),
      .pin_oe_n(general_pin_zero_oe_n)
   );

   mrsp_pin_mux u_pin1 (
      .clk(clk),
      .rst_n(rst_n),
      .sel(pin1_output_select[`MRSP_SEL_FIELD]),
      .dsp_level(dsp_pin1),
      .reg_level(pin1_level), // [R18]
      .is_output(pin1_is_output),
      .src(src),
      .pin_out(general_pin_one),
      .pin_oe_n(general_pin_one_oe_n)
   );
endmodule : mrsp_top

//--- dv/mrsp_top_assertions.sv
// port assertions for the mute ramp / status pin block
// assumes one clk domain with the active-low async reset
`timescale 1ns/100ps
module mrsp_chk (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // audio path
   input wire logic emergency_req,
   input wire logic [7:0] vol_a_in,
   input wire logic [7:0] vol_b_in,
   input wire logic zero_a,
   input wire logic zero_b,
   input wire logic [7:0] vol_a,
   input wire logic [7:0] vol_b,
   input wire logic automute_a,
   input wire logic automute_b,
   // pins
   input wire logic pin0_is_output,
   input wire logic pin1_is_output,
   input wire logic general_pin_one,
   input wire logic general_pin_zero_oe_n,
   input wire logic general_pin_one_oe_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // the edge that releases reset still loads the reset value, so skip that attempt
   vola_follow_a: assert property ($past(rst_n) && !emergency_req |=> vol_a == $past(vol_a_in))
      else $error("vol_a missed its input");
   volb_follow_a: assert property ($past(rst_n) && !emergency_req |=> vol_b == $past(vol_b_in))
      else $error("vol_b missed its input");
   pin0_dir_a: assert property (1'b1 |=> general_pin_zero_oe_n != $past(pin0_is_output))
      else $error("pin zero enable wrong");
   pin1_dir_a: assert property (1'b1 |=> general_pin_one_oe_n != $past(pin1_is_output))
      else $error("pin one enable wrong");
   mute_a_cause_a: assert property (automute_a |-> $past(zero_a))
      else $error("channel A muted without zeros");
   mute_b_cause_a: assert property (automute_b |-> $past(zero_b))
      else $error("channel B muted without zeros");
   // two cycles back so the cycle where the ramp starts is left out
   ramp_down_only_a: assert property ($past(emergency_req) && $past(emergency_req, 2)
      |-> vol_a >= $past(vol_a))
      else $error("emergency ramp raised volume");
   mute_floor_a: assert property ($past(emergency_req) && $past(vol_b) == 8'hff
      |-> vol_b == 8'hff)
      else $error("volume left the mute level");
   cover property (emergency_req && vol_a == 8'hff);
   cover property (automute_a && automute_b);
   cover property (!general_pin_one_oe_n && general_pin_one);
endmodule : mrsp_chk

bind mrsp_top mrsp_chk i_mrsp_chk (.clk, .rst_n, .emergency_req, .vol_a_in, .vol_b_in,
   .zero_a, .zero_b, .vol_a, .vol_b, .automute_a, .automute_b, .pin0_is_output,
   .pin1_is_output, .general_pin_one, .general_pin_zero_oe_n, .general_pin_one_oe_n);

//--- dv/mrsp_top_tb.sv
// self-checking bench for the mute ramp / status pin block
// assumes registers are reached only through the control port pins
`timescale 1ns/100ps
`include "mrsp_regs.svh"
module mrsp_top_tb;
   logic clk = 0, rst_n = 0, scl_pin = 1, sda_m = 1, fs_tick = 0, emergency_req = 0, ak;
   logic [7:0] vol_a_in = 0, vol_b_in = 0, vol_a, vol_b, q, v, w;
   logic sda_pin_out, sda_pin_oe_n, automute_a, automute_b, gp0, gp0_oe_n, gp1, gp1_oe_n;
   logic [15:0] s = 0;
   logic [31:0] t0, t1;
   logic [7:0] areg [5] = '{`MRSP_OFS_EMERG, `MRSP_OFS_AMUTE, `MRSP_OFS_SEL1, `MRSP_OFS_SEL0, 8'h44};
   logic [7:0] mreg [logic [7:0]] = '{`MRSP_OFS_EMERG: `MRSP_RST_EMERG,
      `MRSP_OFS_AMUTE: `MRSP_RST_AMUTE, `MRSP_OFS_SEL1: 8'h00, `MRSP_OFS_SEL0: 8'h00};
   int bad_count = 0, num_checks = 0, seed = 83498, e0, e1, v0, v1, dv, st, up;
   // open-drain data line, released level pulled high
   wire sda_w = sda_pin_oe_n ? sda_m : sda_pin_out;

   mrsp_top i_mrsp_top (.clk, .rst_n, .scl_pin, .sda_pin_in(sda_w), .sda_pin_out, .sda_pin_oe_n,
      .fs_tick, .emergency_req, .vol_a_in, .vol_b_in, .zero_a(s[0]), .zero_b(s[1]), .vol_a,
      .vol_b, .automute_a, .automute_b, .dsp_pin0(s[2]), .dsp_pin1(s[3]), .pin0_level(s[4]),
      .pin1_level(s[5]), .pin0_is_output(s[6]), .pin1_is_output(s[7]), .clk_invalid(s[8]),
      .serial_audio_out(s[9]), .pll_lock(s[10]), .cp_clk(s[11]), .pll_div4(s[12]),
      .uv_high_thresh(s[13]), .uv_low_thresh(s[14]), .general_pin_zero(gp0),
      .general_pin_zero_oe_n(gp0_oe_n), .general_pin_one(gp1), .general_pin_one_oe_n(gp1_oe_n));

   initial begin
      forever #5 clk = ~clk;
   end

   // expected pin level per selector code, with policy 0 and both channels enabled
   function automatic logic [31:0] tab(input logic dsp, input logic lvl);
      return {15'h0, s[12], s[14], s[13], 2'b0, s[11], s[10], ~s[0], ~s[1], s[9], s[8],
         s[0], s[1], s[0] & s[1], lvl, dsp, 1'b0};
   endfunction : tab

   task automatic clks(input int n);
      repeat (n) @(posedge clk);
   endtask : clks

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // data moves only while the clock line is low, three cycles clear of its fall
   task automatic bitx(input logic b, output logic r);
      sda_m <= b;
      clks(5);
      scl_pin <= 1;
      clks(6);
      r = sda_w;
      scl_pin <= 0;
      clks(3);
   endtask : bitx

   task automatic xb(input logic [7:0] d, output logic [7:0] r, input logic m);
      logic a;
      for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
      bitx(1'b1, a);
      if (m) ak |= a;
   endtask : xb

   task automatic start;
      sda_m <= 1;
      clks(3);
      scl_pin <= 1;
      clks(5);
      sda_m <= 0;
      clks(5);
      scl_pin <= 0;
      clks(3);
   endtask : start

   task automatic stop;
      sda_m <= 0;
      clks(3);
      scl_pin <= 1;
      clks(5);
      sda_m <= 1;
      clks(5);
   endtask : stop

   task automatic wr(input logic [7:0] a, input logic [7:0] d [$]);
      ak = 0;
      start;
      xb({`MRSP_DEV_ADDR, 1'b0}, q, 1);
      xb(a, q, 1);
      foreach (d[i]) xb(d[i], q, 1);
      stop;
      chk({7'h0, ak}, 8'h00);
   endtask : wr

   task automatic rchk(input logic [7:0] a);
      ak = 0;
      start;
      xb({`MRSP_DEV_ADDR, 1'b0}, q, 1);
      xb(a, q, 1);
      start;
      xb({`MRSP_DEV_ADDR, 1'b1}, q, 1);
      xb(8'hff, w, 0);
      stop;
      chk({7'h0, ak}, 8'h00);
      chk(w, mreg.exists(a) ? mreg[a] : 8'h00);
   endtask : rchk

   task automatic stop_test;
      $display("checks=%0d errors=%0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test

   initial begin
      #600000;
      bad_count++;
      stop_test;
   end

   initial begin
      clks(2);
      rst_n <= 1;
      clks(4);
      foreach (areg[i]) rchk(areg[i]);
      v = 8'($random(seed));
      // two bytes in one transfer land in two registers; unmapped writes vanish
      wr(`MRSP_OFS_SEL1, '{v, ~v});
      mreg[`MRSP_OFS_SEL1] = v;
      mreg[`MRSP_OFS_SEL0] = ~v;
      wr(8'h44, '{8'h5a});
      foreach (areg[i]) rchk(areg[i]);
      for (int c = 0; c < 8; c++) begin
         wr(`MRSP_OFS_AMUTE, '{8'(c)});
         for (int z = 0; z < 4; z++) begin
            s <= 16'(z);
            clks(3);
            e0 = c[1] & z[0];
            e1 = c[0] & z[1];
            if (c[2]) begin
               e0 = e0 & e1;
               e1 = e0;
            end
            chk({6'h0, automute_b, automute_a}, {6'h0, 1'(e1), 1'(e0)});
         end
      end
      for (int c = 0; c < 16; c++) begin
         wr(`MRSP_OFS_EMERG, '{{4'(c), 4'h0}});
         v0 = $random(seed) & 8'hdf;
         v1 = $random(seed) & 8'hff;
         vol_a_in <= 8'(v0);
         vol_b_in <= 8'(v1);
         clks(2);
         emergency_req <= 1;
         dv = (c >> 2) == 3 ? 0 : 1 << (c >> 2);
         st = 8 >> (c & 3);
         up = 0;
         for (int k = 1; k <= 9; k++) begin
            clks(3);
            fs_tick <= 1;
            clks(1);
            fs_tick <= 0;
            clks(1);
            if (dv != 0 && k % dv == 0) up++;
            e0 = (dv == 0 || v0 + up * st > 255) ? 255 : v0 + up * st;
            e1 = (dv == 0 || v1 + up * st > 255) ? 255 : v1 + up * st;
            chk(vol_a, 8'(e0));
            chk(vol_b, 8'(e1));
         end
         emergency_req <= 0;
         clks(2);
         chk(vol_a, vol_a_in);
         chk(vol_b, vol_b_in);
      end
      wr(`MRSP_OFS_AMUTE, '{8'h03});
      for (int c = 0; c < 32; c++) begin
         wr(`MRSP_OFS_SEL1, '{8'(c), 8'(c)});
         for (int k = 0; k < 4; k++) begin
            s <= 16'($random(seed));
            clks(6);
            t0 = tab(s[2], s[4]);
            t1 = tab(s[3], s[5]);
            chk({4'h0, gp1_oe_n, gp1, gp0_oe_n, gp0}, {4'h0, ~s[7], t1[c], ~s[6], t0[c]});
         end
      end
      stop_test;
   end
endmodule : mrsp_top_tb
